// File: hdl/aopc_delay.sv
// Fixed pipeline delay for a word and its flag
module aopc_delay #(
   parameter int W     = 13,
   parameter int DEPTH = 10
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] pipe      [DEPTH];
   logic [W-1:0] next_pipe [DEPTH];

   always_comb
   begin
      next_pipe[0] = d;
      for (int i = 1; i < DEPTH; i++)
         next_pipe[i] = pipe[i-1];
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < DEPTH; i++)
            pipe[i] <= '0;
      end
      else
      begin
         for (int i = 0; i < DEPTH; i++)
            pipe[i] <= next_pipe[i];
      end
   end

   assign q = pipe[DEPTH-1];
endmodule : aopc_delay

// File: hdl/aopc_pkg.sv
// Types for the converter output, offset and power control block
package aopc_pkg;
   typedef enum logic [1:0] {
      AOPC_RUN,
      AOPC_SLEEP,
      AOPC_WAKE
   } aopc_pwr_e;
   typedef logic [11:0] aopc_word_t;
endpackage : aopc_pkg

// File: hdl/aopc_regs.svh
// Constants for the converter output, offset and power control block
`ifndef AOPC_REGS_SVH
`define AOPC_REGS_SVH
`define AOPC_SAMPLE_W        12
`define AOPC_FAST_LATENCY    10
`define AOPC_SPAN_BASE_LOG2  20
`define AOPC_SPAN_MAX_CODE   4'h0_b
`define AOPC_POS_FULL_OB     12'hfff
`define AOPC_NEG_FULL_OB     12'h000
`define AOPC_SIGN_FLIP       12'h800
`define AOPC_CLK_MHZ         250
`define AOPC_FULL_WAKE_US    100
`define AOPC_CORE_WAKE_US    5
`define AOPC_DRV_WAKE_NS     100
`define AOPC_SLOW_RATE_MSPS  1
`define AOPC_FULL_WAKE_CYC   (`AOPC_FULL_WAKE_US * `AOPC_CLK_MHZ)
`define AOPC_CORE_WAKE_CYC   (`AOPC_CORE_WAKE_US * `AOPC_CLK_MHZ)
`define AOPC_DRV_WAKE_CYC    ((`AOPC_DRV_WAKE_NS * `AOPC_CLK_MHZ) / 1000)
`define AOPC_SLOW_LIMIT_CYC  (`AOPC_CLK_MHZ / `AOPC_SLOW_RATE_MSPS)
`endif

// File: hdl/aopc_sync.sv
// Two flip-flop synchroniser for one level
module aopc_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic d,
   output logic      q
);
   logic meta;
   logic next_meta;
   logic next_q;

   always_comb
   begin
      next_meta = d;
      next_q    = meta;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule : aopc_sync

// File: hdl/aopc_top.sv
// Output formatting, offset cancellation and power control of the converter back end
// What this block does
// [R1] With cancellation on, estimate offset and subtract it from every sample
// [R2] Four-bit loop span picks 1M doubling to 2G cycles; codes above 1011 reserved
// [R3] Hold bit freezes the estimate; last estimate keeps being applied
// [R4] After reset cancellation is off and the fast path is active
// [R5] Controller clears the fast path first, then enables cancellation and span
// [R6] Fast path sends raw samples out after ten cycles, no processing
// [R7] Full-chip sleep powers down all, outputs float; data valid 100 us after wake
// [R8] Core sleep powers down only the core; data valid 5 us after wake
// [R9] Register bit or drive pin floats the outputs; drivers back in 100 ns
// [R10] Low-power mode entered when the sampling clock falls below 1 MSPS
// [R11] Each 12-bit word leaves with an output clock synchronous to it
// [R12] Interface bit or format pin picks DDR LVDS or parallel CMOS
// [R13] DDR: two bits per pair, even bits at falling, odd at rising edge
// [R14] Receiver captures on both output clock edges in DDR mode
// [R15] Separate double-strength controls for data and clock drivers, plus swing
// [R16] CMOS: one bit per pin each cycle, latch on output clock rising edge
// [R17] Overrange flag high in every overloaded cycle, in either interface mode
// [R18] Overload saturates to full scale in the selected coding
// [R19] Coding bit, or format pin in pin configuration mode, picks the coding
// [R20] Overrange flag leaves in the same cycle as its sample word
`include "aopc_regs.svh"
module aopc_top #(
   parameter int         W          = 12,
   parameter int         LAT        = `AOPC_FAST_LATENCY,
   parameter int         FULL_WAKE  = `AOPC_FULL_WAKE_CYC,
   parameter int         CORE_WAKE  = `AOPC_CORE_WAKE_CYC,
   parameter int         SPAN_BASE  = `AOPC_SPAN_BASE_LOG2
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         sample_clk,
   input  wire logic [W-1:0] raw_sample,
   input  wire logic         raw_over_pos,
   input  wire logic         raw_over_neg,
   input  wire logic         fast_path_bypass_off,
   input  wire logic         dc_cancel_enable,
   input  wire logic [3:0]   dc_cancel_loop_span,
   input  wire logic         dc_cancel_hold,
   input  wire logic         full_chip_sleep,
   input  wire logic         core_sleep,
   input  wire logic         output_driver_off,
   input  wire logic         output_drive_pin,
   input  wire logic         pin_config_mode,
   input  wire logic         interface_cmos,
   input  wire logic         format_select_pin,
   input  wire logic         coding_twos,
   input  wire logic         data_driver_double,
   input  wire logic         clock_driver_double,
   input  wire logic [3:0]   swing_level,
   output logic [W/2-1:0]    lvds_data,
   output logic [W-1:0]      cmos_data,
   output logic              output_clock,
   output logic              overrange_flag,
   output logic              outputs_oe_n,
   output logic              data_valid,
   output logic              core_powered,
   output logic              ref_powered,
   output logic              low_power,
   output logic              lvds_mode,
   output logic              data_double,
   output logic              clock_double,
   output logic [3:0]        swing
);
   localparam int SLOW_LIMIT = `AOPC_SLOW_LIMIT_CYC;
   localparam int DRV_WAKE   = `AOPC_DRV_WAKE_CYC;
   localparam int ACC_W      = W + 32;

   // Sampling clock edges from the pin
   logic sclk_s;
   logic sclk_d;
   logic next_sclk_d;
   logic s_edge;

   aopc_sync u_sync_clk (
      .clk  (clk),
      .rstn (rstn),
      .d    (sample_clk),
      .q    (sclk_s)
   );

   logic drv_pin_s;
   aopc_sync u_sync_oe (
      .clk  (clk),
      .rstn (rstn),
      .d    (output_drive_pin),
      .q    (drv_pin_s)
   );

   logic fmt_pin_s;
   aopc_sync u_sync_fmt (
      .clk  (clk),
      .rstn (rstn),
      .d    (format_select_pin),
      .q    (fmt_pin_s)
   );

   assign next_sclk_d = sclk_s;
   assign s_edge      = sclk_s & ~sclk_d;

   // Clock-stop watchdog
   logic [15:0] gap_cnt;
   logic [15:0] next_gap_cnt;
   logic        next_low_power;

   always_comb
   begin
      next_gap_cnt   = gap_cnt;
      next_low_power = low_power;
      if (s_edge)
      begin
         next_gap_cnt   = '0;
         next_low_power = 1'b0;
      end
      else if (gap_cnt >= 16'(SLOW_LIMIT))
         next_low_power = 1'b1; // [R10]
      else
         next_gap_cnt = gap_cnt + 16'h0001;
   end

   // Power state and wake timer
   aopc_pkg::aopc_pwr_e pwr;
   aopc_pkg::aopc_pwr_e next_pwr;
   logic [31:0]         wake_cnt;
   logic [31:0]         next_wake_cnt;
   logic                was_full;
   logic                next_was_full;

   always_comb
   begin
      next_pwr      = pwr;
      next_wake_cnt = wake_cnt;
      next_was_full = was_full;
      case (pwr)
         aopc_pkg::AOPC_RUN:
            if (full_chip_sleep || core_sleep)
            begin
               next_pwr      = aopc_pkg::AOPC_SLEEP;
               next_was_full = full_chip_sleep;
            end
         aopc_pkg::AOPC_SLEEP:
         begin
            if (full_chip_sleep)
               next_was_full = 1'b1;
            if (!full_chip_sleep && !core_sleep)
            begin
               next_pwr      = aopc_pkg::AOPC_WAKE;
               // [R7] [R8]
               next_wake_cnt = was_full ? 32'(FULL_WAKE) : 32'(CORE_WAKE);
            end
         end
         aopc_pkg::AOPC_WAKE:
            if (full_chip_sleep || core_sleep)
            begin
               next_pwr      = aopc_pkg::AOPC_SLEEP;
               next_was_full = was_full | full_chip_sleep;
            end
            else if (wake_cnt <= 32'h0000_0001)
               next_pwr = aopc_pkg::AOPC_RUN;
            else
               next_wake_cnt = wake_cnt - 32'h0000_0001;
         default:
            next_pwr = aopc_pkg::AOPC_RUN;
      endcase
   end

   assign core_powered = (pwr != aopc_pkg::AOPC_SLEEP) && !low_power; // [R8] [R10]
   assign ref_powered  = !((pwr == aopc_pkg::AOPC_SLEEP) && was_full); // [R7]
   assign data_valid   = (pwr == aopc_pkg::AOPC_RUN) && !low_power;

   // Output driver enable with resume delay
   logic       drv_off_req;
   logic       drv_on;
   logic       next_drv_on;
   logic [7:0] drv_cnt;
   logic [7:0] next_drv_cnt;

   assign drv_off_req = output_driver_off || drv_pin_s || full_chip_sleep; // [R9] [R7]

   always_comb
   begin
      next_drv_on  = drv_on;
      next_drv_cnt = drv_cnt;
      if (drv_off_req)
      begin
         next_drv_on  = 1'b0;
         next_drv_cnt = 8'(DRV_WAKE);
      end
      else if (!drv_on)
      begin
         if (drv_cnt <= 8'h01)
            next_drv_on = 1'b1; // [R9]
         else
            next_drv_cnt = drv_cnt - 8'h01;
      end
   end

   assign outputs_oe_n = !drv_on;

   // Mode selection
   assign lvds_mode    = pin_config_mode ? !fmt_pin_s : !interface_cmos; // [R12]
   assign data_double  = data_driver_double; // [R15]
   assign clock_double = clock_driver_double; // [R15]
   assign swing        = swing_level; // [R15]

   logic twos;
   assign twos = pin_config_mode ? fmt_pin_s : coding_twos; // [R19]

   // Offset estimate: leaky integrator with span set by the loop code
   logic signed [ACC_W-1:0] acc;
   logic signed [ACC_W-1:0] next_acc;
   logic [5:0]              shift;
   logic signed [W-1:0]     offset;
   logic signed [W:0]       centred;
   logic                    dc_on;

   assign dc_on   = fast_path_bypass_off && dc_cancel_enable; // [R4] [R5]
   assign shift   = 6'(SPAN_BASE) + ((dc_cancel_loop_span > `AOPC_SPAN_MAX_CODE)
                    ? 6'(`AOPC_SPAN_MAX_CODE) : 6'(dc_cancel_loop_span)); // [R2]
   assign offset  = W'(acc >>> shift);
   assign centred = $signed({1'b0, raw_sample}) - $signed({1'b0, `AOPC_SIGN_FLIP});

   always_comb
   begin
      next_acc = acc;
      if (!dc_on)
         next_acc = '0;
      else if (s_edge && !dc_cancel_hold && !raw_over_pos && !raw_over_neg) // [R1] [R3]
         next_acc = acc + ACC_W'(centred) - (acc >>> shift);
   end

   // Sample processing, capture on each rising sampling clock edge
   logic [W-1:0] proc;
   logic signed [W+1:0] corr;
   logic         over;
   logic [W-1:0] word;

   always_comb
   begin
      corr = (W+2)'($signed({2'b00, raw_sample})) - (W+2)'(offset); // [R1]
      if (!fast_path_bypass_off || !dc_on)
         proc = raw_sample; // [R6]
      else if (corr < 0)
         proc = `AOPC_NEG_FULL_OB;
      else if (corr > (W+2)'(`AOPC_POS_FULL_OB))
         proc = `AOPC_POS_FULL_OB;
      else
         proc = corr[W-1:0];
      over = raw_over_pos || raw_over_neg; // [R17]
      if (raw_over_pos)
         word = `AOPC_POS_FULL_OB; // [R18]
      else if (raw_over_neg)
         word = `AOPC_NEG_FULL_OB; // [R18]
      else
         word = proc;
      if (twos)
         word = word ^ `AOPC_SIGN_FLIP; // [R18] [R19]
   end

   // Ten-stage pipe moves on sampling edges only; flag travels with its word
   logic [W:0] pipe      [LAT];
   logic [W:0] next_pipe [LAT];

   always_comb
   begin
      for (int i = 0; i < LAT; i++)
         next_pipe[i] = pipe[i];
      if (s_edge)
      begin
         next_pipe[0] = {over, word}; // [R20]
         for (int i = 1; i < LAT; i++)
            next_pipe[i] = pipe[i-1]; // [R6]
      end
   end

   // Output stage: data, overrange and output clock
   logic [W:0]     out_q;
   logic [W-1:0]   next_cmos;
   logic [W/2-1:0] next_lvds;
   logic           next_oclk;
   logic           next_ovr;

   aopc_delay #(
      .W     (W+1),
      .DEPTH (1)
   ) u_out_reg (
      .clk  (clk),
      .rstn (rstn),
      .d    (pipe[LAT-1]),
      .q    (out_q)
   );

   always_comb
   begin
      next_oclk = sclk_d; // [R11]
      next_ovr  = out_q[W]; // [R17] [R20]
      next_cmos = out_q[W-1:0]; // [R16]
      for (int i = 0; i < W/2; i++)
         next_lvds[i] = sclk_d ? out_q[2*i+1] : out_q[2*i]; // [R13] [R14]
      if (!data_valid)
      begin
         next_cmos = '0;
         next_lvds = '0;
         next_ovr  = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sclk_d         <= 1'b0;
         gap_cnt        <= '0;
         low_power      <= 1'b0;
         pwr            <= aopc_pkg::AOPC_RUN;
         wake_cnt       <= '0;
         was_full       <= 1'b0;
         drv_on         <= 1'b1;
         drv_cnt        <= '0;
         acc            <= '0;
         output_clock   <= 1'b0;
         overrange_flag <= 1'b0;
         cmos_data      <= '0;
         lvds_data      <= '0;
         for (int i = 0; i < LAT; i++)
            pipe[i] <= '0;
      end
      else
      begin
         sclk_d         <= next_sclk_d;
         gap_cnt        <= next_gap_cnt;
         low_power      <= next_low_power;
         pwr            <= next_pwr;
         wake_cnt       <= next_wake_cnt;
         was_full       <= next_was_full;
         drv_on         <= next_drv_on;
         drv_cnt        <= next_drv_cnt;
         acc            <= next_acc;
         output_clock   <= next_oclk;
         overrange_flag <= next_ovr;
         cmos_data      <= next_cmos;
         lvds_data      <= next_lvds;
         for (int i = 0; i < LAT; i++)
            pipe[i] <= next_pipe[i];
      end
   end

   // Overrange reaches the pin together with its saturated word
   // Either coding, since the coding may change while words are in flight
   property p_ovr_word;
      @(posedge clk) disable iff (!rstn)
      overrange_flag |->
         (cmos_data[W-2:0] == {(W-1){1'b1}} || cmos_data[W-2:0] == {(W-1){1'b0}});
   endproperty
   a_ovr_word: assert property (p_ovr_word) // [R20]
      else $error("overrange without full-scale word");

   property p_hiz;
      @(posedge clk) disable iff (!rstn)
      (output_driver_off || full_chip_sleep) |=> outputs_oe_n;
   endproperty
   a_hiz: assert property (p_hiz) // [R9]
      else $error("drivers still on while off requested");

   property p_fast_raw;
      @(posedge clk) disable iff (!rstn)
      (!fast_path_bypass_off && !raw_over_pos && !raw_over_neg && !twos) |-> proc == raw_sample;
   endproperty
   a_fast_raw: assert property (p_fast_raw) // [R6]
      else $error("fast path altered the sample");

   property p_hold;
      @(posedge clk) disable iff (!rstn)
      (dc_on && dc_cancel_hold && $past(dc_on) && $past(dc_cancel_hold)) |->
         acc == $past(acc);
   endproperty
   a_hold: assert property (p_hold) // [R3]
      else $error("estimate moved while held");

   property p_slow;
      @(posedge clk) disable iff (!rstn)
      (gap_cnt >= 16'(SLOW_LIMIT) && !s_edge) |=> low_power;
   endproperty
   a_slow: assert property (p_slow) // [R10]
      else $error("no low power after clock stop");

   property p_core;
      @(posedge clk) disable iff (!rstn)
      (pwr == aopc_pkg::AOPC_RUN && core_sleep) |=> !core_powered;
   endproperty
   a_core: assert property (p_core) // [R8]
      else $error("core not powered down");

   property p_dis;
      @(posedge clk) disable iff (!rstn)
      !dc_on |=> acc == '0;
   endproperty
   a_dis: assert property (p_dis) // [R1]
      else $error("estimate kept while disabled");

   property p_oclk;
      @(posedge clk) disable iff (!rstn)
      s_edge |-> ##2 output_clock;
   endproperty
   a_oclk: assert property (p_oclk) // [R11]
      else $error("output clock not following sample clock");
endmodule : aopc_top

// File: sim/aopc_capture.sv
// Downstream capture model for the converter output words
module aopc_capture (
   input  wire logic        output_clock,
   input  wire logic [11:0] cmos_data,
   input  wire logic [5:0]  lvds_data,
   input  wire logic        overrange_flag,
   output logic      [11:0] cmos_word,
   output logic      [11:0] ddr_word,
   output logic             over_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] asm_w;
   initial
   begin
      cmos_word = 12'h0_000;
      ddr_word = 12'h0_000;
      over_seen = 1'b0;
      asm_w = 12'h0_000;
   end
   // Word and flag latched mid-period, away from the word update
   always @(negedge output_clock)
   begin
      cmos_word = cmos_data;
      over_seen = overrange_flag;
   end
   // Odd bits in the high phase, even bits in the low phase
   always @(posedge output_clock)
   begin
      #8;
      for (int i = 0; i < 6; i++) asm_w[2*i+1] = lvds_data[i];
      @(negedge output_clock);
      #8;
      for (int i = 0; i < 6; i++) asm_w[2*i] = lvds_data[i];
      ddr_word = asm_w;
   end
endmodule : aopc_capture

// File: sim/testbench.sv
// Self-checking bench for the converter output, offset and power block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rstn, sample_clk, sclk_on, ramp;
   logic [11:0] raw_sample, cmos_data, cmos_word, ddr_word, w0;
   logic        raw_over_pos, raw_over_neg, fast_path_bypass_off, dc_cancel_enable;
   logic [3:0]  dc_cancel_loop_span, swing_level, swing;
   logic        dc_cancel_hold, full_chip_sleep, core_sleep, output_driver_off;
   logic        output_drive_pin, pin_config_mode, interface_cmos, format_select_pin;
   logic        coding_twos, data_driver_double, clock_driver_double, over_seen;
   logic [5:0]  lvds_data;
   logic        output_clock, overrange_flag, outputs_oe_n, data_valid, core_powered;
   logic        ref_powered, low_power, lvds_mode, data_double, clock_double;
   int          err_total, total_checks;
   logic [11:0] sat [6] = '{12'h0_123, 12'h0_923, 12'h0_fff, 12'h0_7ff, 12'h0_000, 12'h0_800};

   aopc_top #(.W(12), .LAT(10), .FULL_WAKE(20), .CORE_WAKE(10), .SPAN_BASE(2)) dut (
      .clk(clk), .rstn(rstn), .sample_clk(sample_clk), .raw_sample(raw_sample),
      .raw_over_pos(raw_over_pos), .raw_over_neg(raw_over_neg),
      .fast_path_bypass_off(fast_path_bypass_off), .dc_cancel_enable(dc_cancel_enable),
      .dc_cancel_loop_span(dc_cancel_loop_span), .dc_cancel_hold(dc_cancel_hold),
      .full_chip_sleep(full_chip_sleep), .core_sleep(core_sleep),
      .output_driver_off(output_driver_off), .output_drive_pin(output_drive_pin),
      .pin_config_mode(pin_config_mode), .interface_cmos(interface_cmos),
      .format_select_pin(format_select_pin), .coding_twos(coding_twos),
      .data_driver_double(data_driver_double), .clock_driver_double(clock_driver_double),
      .swing_level(swing_level), .lvds_data(lvds_data), .cmos_data(cmos_data),
      .output_clock(output_clock), .overrange_flag(overrange_flag),
      .outputs_oe_n(outputs_oe_n), .data_valid(data_valid), .core_powered(core_powered),
      .ref_powered(ref_powered), .low_power(low_power), .lvds_mode(lvds_mode),
      .data_double(data_double), .clock_double(clock_double), .swing(swing));

   aopc_capture cap (
      .output_clock(output_clock), .cmos_data(cmos_data), .lvds_data(lvds_data),
      .overrange_flag(overrange_flag), .cmos_word(cmos_word), .ddr_word(ddr_word),
      .over_seen(over_seen));

   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic grab(input int n);
      repeat (n) @(negedge output_clock);
      #10;
      @(negedge clk);
   endtask : grab

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   always #2 clk = ~clk;

   // Sampling clock, unrelated in phase, stands still when switched off
   initial
   begin
      #1;
      forever
      begin
         #16;
         if (sclk_on) sample_clk = ~sample_clk;
      end
   end

   // Ramp advances once per sampling period
   always @(negedge sample_clk)
   begin
      @(negedge clk);
      if (ramp) raw_sample <= raw_sample + 12'h0_001;
   end

   initial
   begin
      #200us;
      err_total++;
      report_and_stop();
   end

   initial
   begin
      {clk, rstn, sample_clk, raw_over_pos, raw_over_neg, fast_path_bypass_off} = '0;
      {dc_cancel_enable, dc_cancel_hold, full_chip_sleep, core_sleep} = '0;
      {output_driver_off, output_drive_pin, pin_config_mode, format_select_pin} = '0;
      {coding_twos, data_driver_double, clock_driver_double} = '0;
      {sclk_on, ramp, interface_cmos} = '1;
      raw_sample = 12'h0_000;
      dc_cancel_loop_span = 4'h0;
      swing_level = 4'h0;
      err_total = 0;
      total_checks = 0;
      cyc(16);
      rstn = 1'b1;
      grab(20);
      for (int k = 0; k < 4; k++)
      begin
         grab(1);
         check("cmos word", cmos_word, raw_sample - 12'h0_00a); // Ten-sample raw path
         check("overrange", {11'h000, over_seen}, 12'h0_000); // No overload
      end
      $display("test fast path done");
      interface_cmos = 1'b0;
      grab(3);
      check("lvds mode", {11'h000, lvds_mode}, 12'h0_001); // Register pick
      check("ddr word", ddr_word, raw_sample - 12'h0_00a); // Two bits a pair
      pin_config_mode = 1'b1;
      format_select_pin = 1'b1;
      cyc(4);
      check("lvds mode", {11'h000, lvds_mode}, 12'h0_000); // Pin picks parallel
      format_select_pin = 1'b0;
      interface_cmos = 1'b1;
      cyc(4);
      check("lvds mode", {11'h000, lvds_mode}, 12'h0_001); // Pin overrides register
      pin_config_mode = 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         data_driver_double = k[0];
         clock_driver_double = !k[0];
         swing_level = 4'h5 + 4'(k);
         cyc(1);
         check("drive", {6'h00, data_double, clock_double, swing},
               {6'h00, k[0], !k[0], 4'h5 + 4'(k)}); // Separate strengths and swing
      end
      $display("test interface done");
      ramp = 1'b0;
      fast_path_bypass_off = 1'b1;
      raw_sample = 12'h0_123;
      for (int k = 0; k < 6; k++)
      begin
         coding_twos = k[0];
         raw_over_pos = (k / 2 == 1);
         raw_over_neg = (k / 2 == 2);
         grab(20);
         check("coded word", cmos_word, sat[k]); // Coding and saturation
         check("overrange", {11'h000, over_seen}, {11'h000, k > 1}); // Flag with word
      end
      {raw_over_pos, raw_over_neg, coding_twos} = '0;
      pin_config_mode = 1'b1;
      format_select_pin = 1'b1;
      grab(20);
      check("pin coding", cmos_word, 12'h0_923); // Pin picks twos complement
      {pin_config_mode, format_select_pin} = '0;
      $display("test coding done");
      raw_sample = 12'h0_840;
      dc_cancel_enable = 1'b1;
      grab(300);
      check("cancelled", {11'h000, cmos_word >= 12'h7fc && cmos_word <= 12'h804},
            12'h0_001); // Offset removed with short span
      dc_cancel_hold = 1'b1;
      grab(20);
      w0 = cmos_word;
      raw_sample = 12'h0_860;
      grab(20);
      check("held", cmos_word, w0 + 12'h0_020); // Frozen correction still applied
      dc_cancel_hold = 1'b0;
      fast_path_bypass_off = 1'b0;
      grab(20);
      check("bypass", cmos_word, 12'h0_860); // Cancel needs fast path off
      dc_cancel_enable = 1'b0;
      $display("test offset done");
      for (int k = 1; k < 3; k++)
      begin
         {output_drive_pin, output_driver_off} = 2'(k);
         cyc(6);
         check("oe", {11'h000, outputs_oe_n}, 12'h0_001); // Floated by bit or pin
         {output_drive_pin, output_driver_off} = 2'b00;
         cyc(15);
         check("oe", {11'h000, outputs_oe_n}, 12'h0_001); // Resume delay
         cyc(20);
         check("oe", {11'h000, outputs_oe_n}, 12'h0_000); // Drivers back
      end
      full_chip_sleep = 1'b1;
      cyc(4);
      check("power", {9'h000, core_powered, ref_powered, outputs_oe_n}, 12'h0_001);
      full_chip_sleep = 1'b0;
      cyc(2);
      check("valid", {11'h000, data_valid}, 12'h0_000); // Wake time pending
      cyc(60);
      check("valid", {11'h000, data_valid}, 12'h0_001); // Awake again
      core_sleep = 1'b1;
      cyc(4);
      check("power", {10'h000, core_powered, ref_powered}, 12'h0_001); // Refs stay up
      core_sleep = 1'b0;
      cyc(2);
      check("valid", {11'h000, data_valid}, 12'h0_000); // Short wake pending
      cyc(40);
      check("valid", {11'h000, data_valid}, 12'h0_001); // Core awake
      $display("test power done");
      sclk_on = 1'b0;
      cyc(300);
      check("slow", {10'h000, low_power, data_valid}, 12'h0_002); // Stopped clock
      sclk_on = 1'b1;
      cyc(60);
      check("slow", {10'h000, low_power, data_valid}, 12'h0_001); // Clock back
      $display("test clock stop done");
      report_and_stop();
   end
endmodule : testbench
